// *** shared/tdm_timing_pkg.sv ***
// Constants, register map and field layout of the TDM stream rate and timing front end.
// Assumes one 50 MHz register clock; the TDM clock and frame pulse pins are sampled on it.
package tdm_timing_pkg;

  // ==========================================================================
  // Sizes.
  localparam int unsigned NUM_STREAMS = 32;
  localparam int unsigned NUM_HIZ = 16;
  localparam int unsigned NUM_OUT_TIMING = 4;
  localparam int unsigned POS_W = 11;
  localparam int unsigned TOTAL_W = 14;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] MODE_OFFSET = 12'h004;
  localparam logic [11:0] OTS_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00c;
  localparam logic [11:0] SIC_BASE = 12'h100;
  localparam logic [11:0] SOC_BASE = 12'h180;
  localparam logic [4:0] ARRAY_SPAN_BITS = 5'h07;

  // ==========================================================================
  // Field positions.
  localparam int unsigned STANDBY_BIT = 2;
  localparam int unsigned CLKSEL_LSB = 5;
  localparam int unsigned FP_POL_BIT = 7;
  localparam int unsigned CK_POL_BIT = 8;
  localparam int unsigned FP_POS_BIT = 9;
  localparam int unsigned CLK_SCHEME_BIT = 11;
  localparam int unsigned LOW_BIDIR_BIT = 6;
  localparam int unsigned HIGH_BIDIR_BIT = 7;
  localparam int unsigned OTS_FP_POL_LSB = 0;
  localparam int unsigned OTS_FP_POS_LSB = 4;
  localparam int unsigned OTS_CK_POL_LSB = 8;
  localparam int unsigned RATE_LSB = 0;
  localparam int unsigned ST_RATE_OVER_BIT = 0;
  localparam int unsigned ST_OVER_CAP_BIT = 1;
  localparam int unsigned ST_GCI_IN_BIT = 2;
  localparam int unsigned ST_FRAME_MISS_BIT = 3;
  localparam int unsigned ST_TOTAL_LSB = 16;

  // ==========================================================================
  // Encodings and reset values.
  localparam logic [1:0] CLK_16M = 2'h0;
  localparam logic [1:0] CLK_8M = 2'h1;
  localparam logic [1:0] CLK_4M = 2'h2;
  localparam logic [3:0] RATE_2M = 4'h0;
  localparam logic [3:0] RATE_4M = 4'h1;
  localparam logic [3:0] RATE_8M = 4'h2;
  localparam logic [3:0] RATE_16M = 4'h3;
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [TOTAL_W-1:0] BASE_CHANNELS = 14'h0020;
  localparam logic [TOTAL_W-1:0] CHANNEL_LIMIT = 14'h1000;
  localparam logic [POS_W-1:0] FRAME_LAST_POS = 11'h7ff;

  typedef struct packed {
    logic clk_scheme;
    logic fp_pos;
    logic ck_pol;
    logic fp_pol;
    logic [1:0] clk_sel;
    logic standby;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{clk_scheme: 1'b0, fp_pos: 1'b0, ck_pol: 1'b0, fp_pol: 1'b0,
                                   clk_sel: 2'h0, standby: 1'b0};

  // ==========================================================================
  // Timing.
  localparam int unsigned FRAME_PERIOD_NS = 125000;
  localparam int unsigned PCLK_PERIOD_NS = 20;
  localparam int unsigned FRAME_PCLK_CYCLES = FRAME_PERIOD_NS / PCLK_PERIOD_NS;
  localparam int unsigned FRAME_TIMEOUT_DEFAULT = 2 * FRAME_PCLK_CYCLES;

endpackage : tdm_timing_pkg

// *** src/tdm_stream_rate_timing.sv ***
// Rate, framing and driver control front end of a 32-in/32-out TDM switch, with APB registers.
// Assumes TDM pins synchronous to pclk and a switching core supplying data and idle flags.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module tdm_stream_rate_timing #(
  parameter int unsigned FRAME_TIMEOUT_CYCLES = tdm_timing_pkg::FRAME_TIMEOUT_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_clock_pin,
  input wire logic input_frame_pulse,
  input wire logic output_drive_enable_pin,
  input wire logic [31:0] serial_in_stream,
  output logic [31:0] in_stream_data,
  output logic [31:0] bidir_rx_data,
  input wire logic [31:0] out_stream_data,
  input wire logic [31:0] out_channel_idle,
  output logic [31:0] serial_out_stream_o,
  output logic [31:0] serial_out_stream_oe,
  input wire logic [31:0] serial_out_stream_i,
  output logic [15:0] external_tristate_control,
  output logic [3:0] output_clock_pin,
  output logic [3:0] output_frame_pulse,
  output logic frame_start,
  output logic [31:0] in_chan_strobe,
  output logic [31:0] out_chan_strobe
);

  // ==========================================================================
  // Register state.
  tdm_timing_pkg::ctrl_s control_register_q;
  logic low_group_bidir_q;
  logic high_group_bidir_q;
  logic [3:0] out_frame_polarity_n_q;
  logic [3:0] out_frame_position_n_q;
  logic [3:0] out_clock_polarity_n_q;
  logic [3:0] input_rate_field_q [32];
  logic [3:0] output_rate_field_q [32];
  logic [31:0] prdata_q;
  logic rate_over_q;
  logic over_capacity_q;
  logic frame_missing_q;
  logic [tdm_timing_pkg::TOTAL_W-1:0] total_q;

  // ==========================================================================
  // Rate helpers.
  function automatic logic rate_valid(input logic [3:0] r);
    rate_valid = (r <= tdm_timing_pkg::RATE_16M);
  endfunction : rate_valid

  function automatic logic [tdm_timing_pkg::POS_W-1:0] chan_mask(input logic [3:0] r);
    unique case (r)
      tdm_timing_pkg::RATE_2M: chan_mask = 11'h03f;
      tdm_timing_pkg::RATE_4M: chan_mask = 11'h01f;
      tdm_timing_pkg::RATE_8M: chan_mask = 11'h00f;
      tdm_timing_pkg::RATE_16M: chan_mask = 11'h007;
      default: chan_mask = 11'h000;
    endcase
  endfunction : chan_mask

  // ==========================================================================
  // Input clock and frame pulse.
  logic ck_q;
  logic fp_seen_q;
  logic ck_edge;
  logic fp_act;
  logic boundary;
  logic gci_in;
  logic [tdm_timing_pkg::POS_W-1:0] pos_q;
  logic [tdm_timing_pkg::POS_W-1:0] pos_d;
  logic [tdm_timing_pkg::POS_W-1:0] step;
  logic [1:0] sel_eff;

  assign gci_in = control_register_q.fp_pos & control_register_q.fp_pol;
  assign ck_edge = control_register_q.ck_pol ? (input_clock_pin & ~ck_q)
                                             : (~input_clock_pin & ck_q);
  assign fp_act = (input_frame_pulse == control_register_q.fp_pol);
  assign boundary = ck_edge & fp_act & ~fp_seen_q;
  assign sel_eff = (control_register_q.clk_sel == 2'h3) ? tdm_timing_pkg::CLK_4M
                                                        : control_register_q.clk_sel;
  assign step = tdm_timing_pkg::POS_W'(1) << sel_eff;
  assign pos_d = boundary ? '0 : (pos_q + step);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_q <= 1'b0;
      fp_seen_q <= 1'b0;
      pos_q <= '0;
      frame_start <= 1'b0;
    end
    else
    begin
      ck_q <= input_clock_pin;
      frame_start <= boundary;
      if (ck_edge)
      begin
        fp_seen_q <= fp_act;
        pos_q <= pos_d;
      end
    end
  end

  // ==========================================================================
  // Channel strobes, one per channel time of each enabled stream.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_chan_strobe <= '0;
      out_chan_strobe <= '0;
    end
    else
    begin
      for (int n = 0; n < 32; n++)
      begin
        in_chan_strobe[n] <= ck_edge & rate_valid(input_rate_field_q[n])
                             & ((pos_d & chan_mask(input_rate_field_q[n])) == '0);
        out_chan_strobe[n] <= ck_edge & rate_valid(output_rate_field_q[n])
                              & ((pos_d & chan_mask(output_rate_field_q[n])) == '0);
      end
    end
  end

  // ==========================================================================
  // Stream pins and external tristate controls.
  logic drive_ok;
  logic [31:0] bidir_mask;

  assign drive_ok = output_drive_enable_pin & control_register_q.standby;
  assign bidir_mask = {{16{high_group_bidir_q}}, {16{low_group_bidir_q}}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_out_stream_o <= '0;
      serial_out_stream_oe <= '0;
      external_tristate_control <= '1;
      in_stream_data <= '0;
      bidir_rx_data <= '0;
    end
    else
    begin
      serial_out_stream_o <= out_stream_data;
      in_stream_data <= serial_in_stream & ~bidir_mask;
      bidir_rx_data <= serial_out_stream_i & bidir_mask;
      for (int n = 0; n < 32; n++)
      begin
        serial_out_stream_oe[n] <= drive_ok & rate_valid(output_rate_field_q[n])
                                   & ~out_channel_idle[n];
      end
      for (int n = 0; n < 16; n++)
      begin
        external_tristate_control[n] <= ~drive_ok | ~rate_valid(output_rate_field_q[n])
                                        | out_channel_idle[n];
      end
    end
  end

  // ==========================================================================
  // Output clocks and frame pulses.
  logic ck_norm;
  logic win_before;
  logic win_after;

  assign ck_norm = control_register_q.ck_pol ? ~input_clock_pin : input_clock_pin;
  assign win_before = (pos_q > (tdm_timing_pkg::FRAME_LAST_POS - step));
  assign win_after = (pos_q < step) & ~win_before;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      output_clock_pin <= '0;
      output_frame_pulse <= '1;
    end
    else
    begin
      for (int n = 0; n < 4; n++)
      begin
        output_clock_pin[n] <= ck_norm ^ out_clock_polarity_n_q[n];
        if (out_frame_polarity_n_q[n] && out_frame_position_n_q[n])
        begin
          output_frame_pulse[n] <= win_after;
        end
        else
        begin
          output_frame_pulse[n] <= ~(win_before | win_after) ^ out_frame_polarity_n_q[n];
        end
      end
    end
  end

  // ==========================================================================
  // Capacity, clock ratio and frame presence checks.
  logic [tdm_timing_pkg::TOTAL_W-1:0] total_c;
  logic rate_over_c;
  logic [3:0] allowed;
  logic [31:0] miss_cnt_q;

  always_comb
  begin
    total_c = '0;
    rate_over_c = 1'b0;
    unique case (sel_eff)
      tdm_timing_pkg::CLK_16M: allowed = tdm_timing_pkg::RATE_16M;
      tdm_timing_pkg::CLK_8M: allowed = tdm_timing_pkg::RATE_4M;
      default: allowed = tdm_timing_pkg::RATE_2M;
    endcase
    for (int n = 0; n < 32; n++)
    begin
      if (rate_valid(input_rate_field_q[n]))
      begin
        total_c = total_c + (tdm_timing_pkg::BASE_CHANNELS << input_rate_field_q[n]);
        rate_over_c = rate_over_c | (input_rate_field_q[n] > allowed);
      end
      if (rate_valid(output_rate_field_q[n]) && !control_register_q.clk_scheme)
      begin
        rate_over_c = rate_over_c | (output_rate_field_q[n] > allowed);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      total_q <= '0;
      rate_over_q <= 1'b0;
      over_capacity_q <= 1'b0;
    end
    else
    begin
      total_q <= total_c;
      rate_over_q <= rate_over_c;
      over_capacity_q <= (total_c > tdm_timing_pkg::CHANNEL_LIMIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      miss_cnt_q <= '0;
      frame_missing_q <= 1'b0;
    end
    else if (boundary)
    begin
      miss_cnt_q <= '0;
      frame_missing_q <= 1'b0;
    end
    else if (miss_cnt_q >= FRAME_TIMEOUT_CYCLES)
    begin
      frame_missing_q <= 1'b1;
    end
    else
    begin
      miss_cnt_q <= miss_cnt_q + 32'h1;
    end
  end

  // ==========================================================================
  // APB slave, zero wait states.
  logic setup;
  logic wr_access;
  logic in_sic;
  logic in_soc;
  logic hit;
  logic [4:0] idx;
  logic [31:0] rdata_c;

  assign setup = psel & ~penable;
  assign idx = paddr[6:2];
  assign in_sic = (paddr[11:7] == tdm_timing_pkg::SIC_BASE[11:7]) && (paddr[1:0] == 2'h0);
  assign in_soc = (paddr[11:7] == tdm_timing_pkg::SOC_BASE[11:7]) && (paddr[1:0] == 2'h0);
  assign hit = in_sic | in_soc | (paddr == tdm_timing_pkg::CTRL_OFFSET)
               | (paddr == tdm_timing_pkg::MODE_OFFSET) | (paddr == tdm_timing_pkg::OTS_OFFSET)
               | (paddr == tdm_timing_pkg::STATUS_OFFSET);
  assign wr_access = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;

  always_comb
  begin
    rdata_c = '0;
    if (in_sic)
    begin
      rdata_c[tdm_timing_pkg::RATE_LSB +: 4] = input_rate_field_q[idx];
    end
    else if (in_soc)
    begin
      rdata_c[tdm_timing_pkg::RATE_LSB +: 4] = output_rate_field_q[idx];
    end
    else if (paddr == tdm_timing_pkg::CTRL_OFFSET)
    begin
      rdata_c[tdm_timing_pkg::STANDBY_BIT] = control_register_q.standby;
      rdata_c[tdm_timing_pkg::CLKSEL_LSB +: 2] = control_register_q.clk_sel;
      rdata_c[tdm_timing_pkg::FP_POL_BIT] = control_register_q.fp_pol;
      rdata_c[tdm_timing_pkg::CK_POL_BIT] = control_register_q.ck_pol;
      rdata_c[tdm_timing_pkg::FP_POS_BIT] = control_register_q.fp_pos;
      rdata_c[tdm_timing_pkg::CLK_SCHEME_BIT] = control_register_q.clk_scheme;
    end
    else if (paddr == tdm_timing_pkg::MODE_OFFSET)
    begin
      rdata_c[tdm_timing_pkg::LOW_BIDIR_BIT] = low_group_bidir_q;
      rdata_c[tdm_timing_pkg::HIGH_BIDIR_BIT] = high_group_bidir_q;
    end
    else if (paddr == tdm_timing_pkg::OTS_OFFSET)
    begin
      rdata_c[tdm_timing_pkg::OTS_FP_POL_LSB +: 4] = out_frame_polarity_n_q;
      rdata_c[tdm_timing_pkg::OTS_FP_POS_LSB +: 4] = out_frame_position_n_q;
      rdata_c[tdm_timing_pkg::OTS_CK_POL_LSB +: 4] = out_clock_polarity_n_q;
    end
    else if (paddr == tdm_timing_pkg::STATUS_OFFSET)
    begin
      rdata_c[tdm_timing_pkg::ST_RATE_OVER_BIT] = rate_over_q;
      rdata_c[tdm_timing_pkg::ST_OVER_CAP_BIT] = over_capacity_q;
      rdata_c[tdm_timing_pkg::ST_GCI_IN_BIT] = gci_in;
      rdata_c[tdm_timing_pkg::ST_FRAME_MISS_BIT] = frame_missing_q;
      rdata_c[tdm_timing_pkg::ST_TOTAL_LSB +: tdm_timing_pkg::TOTAL_W] = total_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (setup && !pwrite)
    begin
      prdata_q <= rdata_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_register_q <= tdm_timing_pkg::CTRL_RESET;
      low_group_bidir_q <= 1'b0;
      high_group_bidir_q <= 1'b0;
      out_frame_polarity_n_q <= '0;
      out_frame_position_n_q <= '0;
      out_clock_polarity_n_q <= '0;
    end
    else if (wr_access)
    begin
      if (paddr == tdm_timing_pkg::CTRL_OFFSET)
      begin
        control_register_q.standby <= pwdata[tdm_timing_pkg::STANDBY_BIT];
        control_register_q.clk_sel <= pwdata[tdm_timing_pkg::CLKSEL_LSB +: 2];
        control_register_q.fp_pol <= pwdata[tdm_timing_pkg::FP_POL_BIT];
        control_register_q.ck_pol <= pwdata[tdm_timing_pkg::CK_POL_BIT];
        control_register_q.fp_pos <= pwdata[tdm_timing_pkg::FP_POS_BIT];
        control_register_q.clk_scheme <= pwdata[tdm_timing_pkg::CLK_SCHEME_BIT];
      end
      if (paddr == tdm_timing_pkg::MODE_OFFSET)
      begin
        low_group_bidir_q <= pwdata[tdm_timing_pkg::LOW_BIDIR_BIT];
        high_group_bidir_q <= pwdata[tdm_timing_pkg::HIGH_BIDIR_BIT];
      end
      if (paddr == tdm_timing_pkg::OTS_OFFSET)
      begin
        out_frame_polarity_n_q <= pwdata[tdm_timing_pkg::OTS_FP_POL_LSB +: 4];
        out_frame_position_n_q <= pwdata[tdm_timing_pkg::OTS_FP_POS_LSB +: 4];
        out_clock_polarity_n_q <= pwdata[tdm_timing_pkg::OTS_CK_POL_LSB +: 4];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int n = 0; n < 32; n++)
      begin
        input_rate_field_q[n] <= tdm_timing_pkg::RATE_RESET;
        output_rate_field_q[n] <= tdm_timing_pkg::RATE_RESET;
      end
    end
    else if (wr_access && in_sic)
    begin
      input_rate_field_q[idx] <= pwdata[tdm_timing_pkg::RATE_LSB +: 4];
    end
    else if (wr_access && in_soc)
    begin
      output_rate_field_q[idx] <= pwdata[tdm_timing_pkg::RATE_LSB +: 4];
    end
  end

endmodule : tdm_stream_rate_timing

`default_nettype wire

// *** tb/tdm_stream_rate_timing_properties.sv ***
// Port assertions of the TDM stream rate and timing front end.
// Assumes it is bound into tdm_stream_rate_timing and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tdm_stream_rate_timing_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic output_drive_enable_pin,
  input wire logic [31:0] serial_in_stream,
  input wire logic [31:0] in_stream_data,
  input wire logic [31:0] bidir_rx_data,
  input wire logic [31:0] serial_out_stream_i,
  input wire logic [31:0] out_channel_idle,
  input wire logic [31:0] serial_out_stream_oe,
  input wire logic [15:0] external_tristate_control,
  input wire logic frame_start
);
  // ==========================================================================
  // Port relations.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_quiet: assert property (
    $rose(presetn) |-> external_tristate_control == 16'hffff && serial_out_stream_oe == 32'h0)
    else $error("drivers active at reset release");
  a_hiz_mirror: assert property (
    external_tristate_control == ~serial_out_stream_oe[15:0])
    else $error("tristate control not inverse of drive");
  a_drive_gate: assert property (
    !output_drive_enable_pin |=> serial_out_stream_oe == 32'h0)
    else $error("outputs driven with drive pin low");
  a_idle_off: assert property (
    (serial_out_stream_oe & $past(out_channel_idle)) == 32'h0)
    else $error("idle channel driven");
  a_group_split: assert property (
    (in_stream_data & bidir_rx_data) == 32'h0)
    else $error("stream seen on both paths");
  a_in_source: assert property (
    ((in_stream_data & ~$past(serial_in_stream)) |
     (bidir_rx_data & ~$past(serial_out_stream_i))) == 32'h0)
    else $error("received data without a source");
  a_frame_single: assert property (
    frame_start |=> !frame_start [*8])
    else $error("frame start repeated");
  a_apb_ready: assert property (
    psel && penable |-> pready)
    else $error("access phase without ready");
endmodule : tdm_stream_rate_timing_properties

bind tdm_stream_rate_timing tdm_stream_rate_timing_properties u_props (.pclk, .presetn, .psel,
  .penable, .pready, .output_drive_enable_pin, .serial_in_stream, .in_stream_data, .bidir_rx_data,
  .serial_out_stream_i, .out_channel_idle, .serial_out_stream_oe, .external_tristate_control,
  .frame_start);
`default_nettype wire

// *** tb/tdm_far_end.sv ***
// Far-end model: source of input clock and frame pulse, and a bidirectional bus peer.
// Assumes pclk runs at four times the modelled input clock.
`timescale 1ns/1ps
`default_nettype none
module tdm_far_end #(
  parameter int unsigned FRAME_CLKS = 2048,
  parameter logic [31:0] PEER_DATA = 32'h5a3cc3a5
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic input_clock_pin,
  output logic input_frame_pulse,
  output logic [31:0] far_data
);
  // ==========================================================================
  // Clock and frame generation.
  logic [1:0] phase_q;
  logic [11:0] period_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q <= 2'h0;
      period_q <= 12'h000;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      if (phase_q == 2'h3)
        period_q <= (period_q == 12'(FRAME_CLKS - 1)) ? 12'h000 : period_q + 12'h001;
    end
  end
  assign input_clock_pin = ~phase_q[1];
  assign input_frame_pulse = (period_q != 12'h000);
  assign far_data = PEER_DATA;
endmodule : tdm_far_end
`default_nettype wire

// *** tb/tdm_stream_rate_timing_tb.sv ***
// Self-checking bench of the TDM stream rate and timing front end.
// Assumes the far-end model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module tdm_stream_rate_timing_tb;
  // ==========================================================================
  // Stimulus and checks.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic output_drive_enable_pin = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] serial_in_stream = 32'hffffffff;
  logic [31:0] out_stream_data = 32'h3c5a96e1;
  logic [31:0] out_channel_idle = 32'h0;
  logic [31:0] prdata, in_stream_data, bidir_rx_data, serial_out_stream_o, serial_out_stream_oe;
  logic [31:0] in_chan_strobe, out_chan_strobe, far_data, rdata;
  logic [15:0] external_tristate_control;
  logic [3:0] output_clock_pin, output_frame_pulse;
  logic pready, pslverr, input_clock_pin, input_frame_pulse, frame_start, rerr;
  int n_fail = 0;
  int tests_run = 0;
  wire [31:0] serial_out_stream_i = (serial_out_stream_oe & serial_out_stream_o) |
                                    (~serial_out_stream_oe & far_data);

  tdm_stream_rate_timing #(.FRAME_TIMEOUT_CYCLES(20000)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_clock_pin, .input_frame_pulse,
    .output_drive_enable_pin, .serial_in_stream, .in_stream_data, .bidir_rx_data,
    .out_stream_data, .out_channel_idle, .serial_out_stream_o, .serial_out_stream_oe,
    .serial_out_stream_i, .external_tristate_control, .output_clock_pin, .output_frame_pulse,
    .frame_start, .in_chan_strobe, .out_chan_strobe);
  tdm_far_end u_far (.pclk, .presetn, .input_clock_pin, .input_frame_pulse, .far_data);

  always #10 pclk = ~pclk;

  function automatic logic [11:0] sic(input int i);
    return tdm_timing_pkg::SIC_BASE + 12'(4 * i);
  endfunction : sic

  function automatic logic [11:0] soc(input int i);
    return tdm_timing_pkg::SOC_BASE + 12'(4 * i);
  endfunction : soc

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdm(input string nm, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdata & m);
  endtask : rdm

  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  task automatic t_reset;
    chk("hiz", 32'hffff, {16'h0, external_tristate_control});
    chk("oe", 32'h0, serial_out_stream_oe);
    rdm("ctrl", tdm_timing_pkg::CTRL_OFFSET, 32'hffffffff, 32'h0);
    rdm("mode", tdm_timing_pkg::MODE_OFFSET, 32'hffffffff, 32'h0);
    rdm("hole", 12'h010, 32'hffffffff, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
  endtask : t_reset

  task automatic t_regs;
    for (int i = 0; i < 4; i++)
    begin
      wr(sic(i), 32'(i));
      wr(soc(i), 32'hfffffff0 | 32'(3 - i));
      rdm("in rate", sic(i), 32'hffffffff, 32'(i));
      rdm("out rate", soc(i), 32'hffffffff, 32'(3 - i));
    end
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'hffffffff);
    rdm("ctrl", tdm_timing_pkg::CTRL_OFFSET, 32'hffffffff, 32'h00000be4);
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'h280);
    rdm("gci", tdm_timing_pkg::STATUS_OFFSET, 32'h4, 32'h4);
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'h080);
    rdm("gci", tdm_timing_pkg::STATUS_OFFSET, 32'h4, 32'h0);
  endtask : t_regs

  task automatic t_total;
    for (int i = 0; i < 32; i++)
      wr(sic(i), 32'h2);
    rdm("total", tdm_timing_pkg::STATUS_OFFSET, 32'h3fff0002, 32'h10000000);
    wr(sic(5), 32'hf);
    rdm("total", tdm_timing_pkg::STATUS_OFFSET, 32'h3fff0002, 32'h0f800000);
    wr(sic(5), 32'h3);
    rdm("total", tdm_timing_pkg::STATUS_OFFSET, 32'h3fff0002, 32'h10800002);
  endtask : t_total

  task automatic t_drive;
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'h4);
    wr(soc(9), 32'h8);
    out_channel_idle <= 32'h00ff00ff;
    settle();
    chk("oe", 32'hff00fd00, serial_out_stream_oe);
    chk("hiz", 32'h02ff, {16'h0, external_tristate_control});
    chk("out", out_stream_data, serial_out_stream_o);
    @(posedge pclk);
    output_drive_enable_pin <= 1'b0;
    settle();
    chk("hiz", 32'hffff, {16'h0, external_tristate_control});
    @(posedge pclk);
    output_drive_enable_pin <= 1'b1;
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'h0);
    settle();
    chk("oe", 32'h0, serial_out_stream_oe);
  endtask : t_drive

  task automatic t_bidir;
    logic [31:0] msk;
    @(posedge pclk);
    output_drive_enable_pin <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      wr(tdm_timing_pkg::MODE_OFFSET, 32'(m) << 6);
      msk = {{16{m[1]}}, {16{m[0]}}};
      settle();
      chk("in", ~msk, in_stream_data);
      chk("rx", msk & far_data, bidir_rx_data);
    end
    wr(tdm_timing_pkg::MODE_OFFSET, 32'h0);
    output_drive_enable_pin <= 1'b1;
  endtask : t_bidir

  task automatic t_frame;
    int s[5];
    int n;
    wr(tdm_timing_pkg::CTRL_OFFSET, 32'h4);
    wr(sic(0), 32'h0);
    wr(sic(1), 32'h3);
    wr(sic(2), 32'h8);
    wr(soc(0), 32'h2);
    wr(soc(1), 32'h1);
    wr(tdm_timing_pkg::OTS_OFFSET, 32'h24c);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (frame_start !== 1'b1 && n < 20000);
    s = '{0, 0, 0, 0, 0};
    n = 0;
    do
    begin
      s[0] += int'(in_chan_strobe[0]);
      s[1] += int'(in_chan_strobe[1]);
      s[2] += int'(in_chan_strobe[2]);
      s[3] += int'(out_chan_strobe[0]);
      s[4] += int'(out_chan_strobe[1]);
      @(posedge pclk);
      #1;
      n++;
    end
    while (frame_start !== 1'b1 && n < 20000);
    chk("frame", 32'd8192, 32'(n));
    chk("in ch", 32'd32, 32'(s[0]));
    chk("in ch", 32'd256, 32'(s[1]));
    chk("in ch", 32'd0, 32'(s[2]));
    chk("out ch", 32'd128, 32'(s[3]));
    chk("out ch", 32'd64, 32'(s[4]));
    chk("fpo", 32'h8, {28'h0, output_frame_pulse});
    @(posedge pclk);
    #1;
    chk("fpo", 32'hc, {28'h0, output_frame_pulse});
    chk("ckpol", 32'h1, {31'h0, output_clock_pin[0] ^ output_clock_pin[1]});
  endtask : t_frame

  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_total();
    t_drive();
    t_bidir();
    t_frame();
    finish_test();
  end

  initial
  begin
    #1000000;
    n_fail++;
    finish_test();
  end
endmodule : tdm_stream_rate_timing_tb
`default_nettype wire
